// file: pkg/clock_divider_defines.vh
// Constants for the clock divider control block
`ifndef CLOCK_DIVIDER_DEFINES_VH
`define CLOCK_DIVIDER_DEFINES_VH
`define REG_ADDR_WIDTH 4
`define ADDR_CLOCK_DIVIDER_CONTROL 4'h0
`define BIT_RECOVER_ON_IRQ 15
`define BIT_RATIO_MSB 14
`define BIT_RATIO_LSB 12
`define BIT_RATIO_APPLY_EN 11
`define BIT_POSTSCALE_MSB 10
`define BIT_POSTSCALE_LSB 8
`define BIT_FIXED_ONE 6
`define RESET_RECOVER_ON_IRQ 1'h0
`define RESET_PERIPH_RATIO_SEL 3'h3
`define RESET_RATIO_APPLY_EN 1'h0
`define RESET_FAST_RC_POSTSCALE 3'h1
`define RATIO_ONE_TO_ONE 3'h0
`define POSTSCALE_DIV256_CODE 3'h7
`define POSTSCALE_DIV256_SHIFT 4'h8
`define FAST_RC_OSC_KHZ 8000
`define READ_ZERO 16'h0000
`endif

// file: core/ratio_decode.v
// Periph_ratio_sel ratio decode: shift count of the peripheral clock ratio
`timescale 1ns/1ps
`default_nettype none
`include "clock_divider_defines.vh"
module ratio_decode (
  input wire applyEn,
  input wire [2:0] ratioSel,
  output reg [2:0] ratioShift
);
  // Code n means 1:2^n; disabled periph_ratio_sel forces 1:1
  always @* begin
    if (applyEn) begin
      ratioShift = ratioSel;
    end else begin
      ratioShift = `RATIO_ONE_TO_ONE;
    end
  end
endmodule // ratio_decode
`default_nettype wire

// file: core/postscale_decode.v
// Fast RC postscaler decode: code to power-of-two shift
`timescale 1ns/1ps
`default_nettype none
`include "clock_divider_defines.vh"
module postscale_decode (
  input wire [2:0] postscaleSel,
  output reg [3:0] postscaleShift
);
  // Codes 0..6 divide by 2^code; top code jumps to divide-by-256
  always @* begin
    if (postscaleSel == `POSTSCALE_DIV256_CODE) begin
      postscaleShift = `POSTSCALE_DIV256_SHIFT;
    end else begin
      postscaleShift = {1'b0, postscaleSel};
    end
  end
endmodule // postscale_decode
`default_nettype wire

// file: core/periph_ratio_sel_and_rc_postscaler_ctrl.v
// Clock divider control register with periph_ratio_sel and fast RC postscaler selection
`timescale 1ns/1ps
`default_nettype none
`include "clock_divider_defines.vh"
// Notes on behaviour
// - With recover set, an interrupt clears periph_ratio_sel enable, ratio back to 1:1.
// - Periph_ratio_sel enable applies the ratio field; otherwise ratio is forced 1:1.
// - Ratio code n selects a CPU-to-peripheral ratio of 1:2^n.
// - Postscaler code n divides by 2^n, top code divides by 256.
module periph_ratio_sel_and_rc_postscaler_ctrl (
  input wire clock,
  input wire resetn,
  input wire [`REG_ADDR_WIDTH-1:0] address,
  input wire [15:0] writeData,
  input wire writeStrobe,
  input wire readStrobe,
  input wire irqEvent,
  output reg [15:0] readData,
  output reg [2:0] ratioShift,
  output reg [3:0] postscaleShift,
  output reg dozeActive
);
  reg recover_on_irq_reg;
  reg recover_on_irq_next;
  reg [2:0] periph_ratio_sel_reg;
  reg [2:0] periph_ratio_sel_next;
  reg ratio_apply_en_reg;
  reg ratio_apply_en_next;
  reg [2:0] fast_rc_postscale_reg;
  reg [2:0] fast_rc_postscale_next;
  reg [15:0] regImage;
  wire hitDivider;
  wire [2:0] ratioShiftNext;
  wire [3:0] postscaleShiftNext;

  assign hitDivider = (address == `ADDR_CLOCK_DIVIDER_CONTROL);

  // Next register values; an interrupt wins over a same-cycle write of enable
  always @* begin
    recover_on_irq_next = recover_on_irq_reg;
    periph_ratio_sel_next = periph_ratio_sel_reg;
    ratio_apply_en_next = ratio_apply_en_reg;
    fast_rc_postscale_next = fast_rc_postscale_reg;
    if (writeStrobe && hitDivider) begin
      recover_on_irq_next = writeData[`BIT_RECOVER_ON_IRQ];
      periph_ratio_sel_next = writeData[`BIT_RATIO_MSB:`BIT_RATIO_LSB];
      ratio_apply_en_next = writeData[`BIT_RATIO_APPLY_EN];
      fast_rc_postscale_next = writeData[`BIT_POSTSCALE_MSB:`BIT_POSTSCALE_LSB];
    end
    // Recover uses the bit as it stands before this cycle's write
    if (irqEvent && recover_on_irq_reg) begin
      ratio_apply_en_next = 1'b0;
    end
  end

  // Register state
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      recover_on_irq_reg <= `RESET_RECOVER_ON_IRQ;
      periph_ratio_sel_reg <= `RESET_PERIPH_RATIO_SEL;
      ratio_apply_en_reg <= `RESET_RATIO_APPLY_EN;
      fast_rc_postscale_reg <= `RESET_FAST_RC_POSTSCALE;
    end else begin
      recover_on_irq_reg <= recover_on_irq_next;
      periph_ratio_sel_reg <= periph_ratio_sel_next;
      ratio_apply_en_reg <= ratio_apply_en_next;
      fast_rc_postscale_reg <= fast_rc_postscale_next;
    end
  end

  // Read image; only bit 6 of the low byte is a fixed one
  always @* begin
    regImage = `READ_ZERO;
    regImage[`BIT_RECOVER_ON_IRQ] = recover_on_irq_reg;
    regImage[`BIT_RATIO_MSB:`BIT_RATIO_LSB] = periph_ratio_sel_reg;
    regImage[`BIT_RATIO_APPLY_EN] = ratio_apply_en_reg;
    regImage[`BIT_POSTSCALE_MSB:`BIT_POSTSCALE_LSB] = fast_rc_postscale_reg;
    regImage[`BIT_FIXED_ONE] = 1'b1;
  end

  ratio_decode ratioDecode (
    .applyEn(ratio_apply_en_next),
    .ratioSel(periph_ratio_sel_next),
    .ratioShift(ratioShiftNext)
  );

  postscale_decode postscaleDecode (
    .postscaleSel(fast_rc_postscale_next),
    .postscaleShift(postscaleShiftNext)
  );

  // Shift and doze outputs registered from next values so they track the register exactly; readData samples the current image
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      readData <= `READ_ZERO;
      ratioShift <= `RATIO_ONE_TO_ONE;
      postscaleShift <= {1'b0, `RESET_FAST_RC_POSTSCALE};
      dozeActive <= `RESET_RATIO_APPLY_EN;
    end else begin
      // Unmapped reads and idle cycles return zero
      if (readStrobe && hitDivider) begin
        readData <= regImage;
      end else begin
        readData <= `READ_ZERO;
      end
      ratioShift <= ratioShiftNext;
      postscaleShift <= postscaleShiftNext;
      dozeActive <= ratio_apply_en_next;
    end
  end
endmodule // periph_ratio_sel_and_rc_postscaler_ctrl
`default_nettype wire

// file: verification/periph_ratio_sel_props.sv
// Checker on the clock divider control ports
`timescale 1ns/1ps
`default_nettype none
module periph_ratio_sel_props (
  input wire clock, resetn, writeStrobe, readStrobe, irqEvent, dozeActive,
  input wire [3:0] address, postscaleShift,
  input wire [15:0] writeData, readData,
  input wire [2:0] ratioShift
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  wire wrHit = writeStrobe && address == 4'h0;
  reg roiReg;
  // Recover bit shadow; an irq is judged on the old value
  always @(posedge clock or negedge resetn)
    roiReg <= !resetn ? 1'h0 : wrHit ? writeData[15] : roiReg;
  chk_irq_recover: assert property (irqEvent && roiReg |=> !dozeActive) else $error("periph_ratio_sel");
  chk_ratio_forced: assert property (!dozeActive |-> ratioShift == 3'h0) else $error("one");
  chk_ratio_apply: assert property (wrHit && writeData[11] && !(irqEvent && roiReg)
    |=> ratioShift == $past(writeData[14:12])) else $error("ratio");
  chk_post_shift: assert property (wrHit |=> postscaleShift ==
    ($past(writeData[10:8]) == 3'h7 ? 4'h8 : $past(writeData[10:8]))) else $error("post");
  chk_low_byte: assert property (readStrobe && address == 4'h0 |=> readData[7:0] == 8'h40)
    else $error("low");
  chk_reset_load: assert property ($rose(resetn) |-> postscaleShift == 4'h1)
    else $error("reset");
  chk_read_idle: assert property (!(readStrobe && address == 4'h0) |=> readData == 16'h0000)
    else $error("idle");
endmodule // periph_ratio_sel_props
bind periph_ratio_sel_and_rc_postscaler_ctrl periph_ratio_sel_props i_props (
  .clock(clock),
  .resetn(resetn),
  .writeStrobe(writeStrobe),
  .readStrobe(readStrobe),
  .irqEvent(irqEvent),
  .dozeActive(dozeActive),
  .address(address),
  .postscaleShift(postscaleShift),
  .writeData(writeData),
  .readData(readData),
  .ratioShift(ratioShift)
);
`default_nettype wire

// file: verification/test_periph_ratio_sel_and_rc_postscaler_ctrl.sv
// Bench for the clock divider control block
`timescale 1ns/1ps
`default_nettype none
module test_periph_ratio_sel_and_rc_postscaler_ctrl;
  reg clock = 1'h0, resetn = 1'h0, writeStrobe = 1'h0, readStrobe = 1'h0, irqEvent = 1'h0;
  reg rdLate = 1'h0, roiOld = 1'h0;
  reg [15:0] rdImg = 16'h0000;
  reg [3:0] address = 4'h0;
  reg [15:0] writeData = 16'h0000, img = 16'h3140;
  wire [15:0] readData;
  wire [3:0] postscaleShift;
  wire [2:0] ratioShift;
  wire dozeActive;
  reg [23:0] notes[$];
  // Tail rows: the old recover bit judges a same-cycle irq, and the irq beats an enable write
  reg [22:0] plan[0:16] = '{23'h405000, 23'h200000, 23'h401800, 23'h100000, 23'h200000,
    23'h409800, 23'h100000, 23'h200000, 23'h41FFFF, 23'h210000, 23'h200000, 23'h401800,
    23'h509800, 23'h200000, 23'h509800, 23'h200000, 23'h000000};
  integer seed = 32'h6146, n_mismatch = 0, cmp_count = 0, i;
  periph_ratio_sel_and_rc_postscaler_ctrl i_dut (
    .clock(clock),
    .resetn(resetn),
    .address(address),
    .writeData(writeData),
    .writeStrobe(writeStrobe),
    .readStrobe(readStrobe),
    .irqEvent(irqEvent),
    .readData(readData),
    .ratioShift(ratioShift),
    .postscaleShift(postscaleShift),
    .dozeActive(dozeActive)
  );
  always #50 clock = ~clock;
  // One cycle of {write, read, irq, address, data}; a read notes what should come back
  task op(input [22:0] p);
    @(posedge clock);
    {writeStrobe, readStrobe, irqEvent, address, writeData} <= p;
    roiOld = img[15];
    if (p[22] && p[19:16] == 4'h0) img = {p[15:8], 8'h40};
    rdImg = img;
    if (p[20] && roiOld) img[11] = 1'h0;
    if (p[21]) notes.push_back({p[19:16] == 4'h0 ? rdImg : 16'h0000,
      img[11] ? img[14:12] : 3'h0, img[10:8] == 3'h7 ? 4'h8 : {1'h0, img[10:8]}, img[11]});
  endtask
  task check(input [23:0] s, input [23:0] e);
    cmp_count = cmp_count + 1;
    if (s !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("CHECK FAILED outputs expected %h seen %h", e, s);
    end
  endtask
  task results;
    if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Read data stands one cycle after the strobe, so look at the falling edge
  always @(posedge clock) rdLate <= readStrobe;
  always @(negedge clock) if (rdLate)
    check({readData, ratioShift, postscaleShift, dozeActive}, notes.pop_front());
  // Reset, every ratio and postscale code with random low-byte junk, then the table
  initial begin
    repeat (20) @(posedge clock);
    resetn <= 1'h1;
    op(23'h200000);
    for (i = 0; i < 8; i++) begin
      op({3'h4, 4'h0, 1'h0, i[2:0], 1'h1, i[2:0], 8'($random(seed))});
      op(23'h200000);
    end
    for (i = 0; i < 17; i++) op(plan[i]);
    // Mid-run reset with recover and periph_ratio_sel set must bring back the reset image
    op(23'h40F800);
    op(23'h000000);
    resetn <= 1'h0;
    img = 16'h3140;
    repeat (3) @(posedge clock);
    resetn <= 1'h1;
    op(23'h200000);
    op(23'h000000);
    repeat (2) @(posedge clock);
    results;
  end
endmodule // test_periph_ratio_sel_and_rc_postscaler_ctrl
`default_nettype wire
